// ---- axi_lite_slave.sv ----
`timescale 1ns/1ps
module axi_lite_slave
  import usb_tok_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_value,
  input wire logic rd_ok
);

  logic aw_held;
  logic w_held;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_en = aw_held && w_held && !bvalid;
  assign rd_addr = araddr;

  // Address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= resp_okay;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? resp_okay : resp_slverr;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= resp_okay;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_ok ? rd_value : 32'h0000_0000;
      rresp <= rd_ok ? resp_okay : resp_slverr;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : axi_lite_slave

// ---- line_state_filter.sv ----
`timescale 1ns/1ps
module line_state_filter
  import usb_tok_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] log2_count,
  input wire logic [1:0] raw_state,
  output logic [1:0] filt_state
);

  logic [1:0] candidate;
  logic [15:0] count;
  wire [16:0] target = 17'h1_0000 >> (5'h10 - {1'b0, log2_count});
  wire stable_done = ({1'b0, count} + 17'h0_0001) >= target;

  // Change must hold 2^n clocks before it passes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      candidate <= 2'h0;
      count <= 16'h0000;
      filt_state <= 2'h0;
    end else if (raw_state != candidate) begin
      candidate <= raw_state;
      count <= 16'h0000;
    end else if (candidate != filt_state) begin
      if (stable_done) begin
        filt_state <= candidate;
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

endmodule : line_state_filter

// ---- tb.sv ----
`timescale 1ns/1ps
module tb
  import usb_tok_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic suspended = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, utmi_line_state, line_state_filtered, last_resp;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0] utmi_rx_data;
  logic utmi_rx_valid, utmi_rx_active, resume_request, rx_port_valid;
  logic wide_port_a_pulldown_off, wide_port_b_pulldown_off;
  logic [4:0] rx_port_data, port_last;
  logic [2:0] phy_config_pins;
  int mismatches = 0;
  int checks_done = 0;
  int port_hits = 0;
  ////////////////////////////////////////////////////////////////////////////////
  usb_token_capture_phy_ctrl i_usb_token_capture_phy_ctrl (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .utmi_rx_data, .utmi_rx_valid,
    .utmi_rx_active, .utmi_line_state, .suspended, .resume_request, .line_state_filtered,
    .rx_port_data, .rx_port_valid, .phy_config_pins, .wide_port_a_pulldown_off,
    .wide_port_b_pulldown_off);
  usb_phy_model i_usb_phy_model (.aclk, .rx_data(utmi_rx_data), .rx_valid(utmi_rx_valid),
    .rx_active(utmi_rx_active), .line_state(utmi_line_state));
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (rx_port_valid === 1'b1) begin
      port_hits++;
      port_last = rx_port_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Waits end only on the answer; the watchdog covers a dead bus
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    last_resp = s_axi_bresp;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    last_resp = s_axi_rresp;
  endtask : axr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    axr(a);
    chk({last_resp, rd}, {r, e});
  endtask : rc
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_vals;
    logic [7:0] regs [6];
    regs = '{addr_last_packet_id, addr_last_endpoint, addr_endpoint_mark_mask,
             addr_otg_flag_mask, addr_power_signalling, addr_phy_control};
    foreach (regs[i]) rc(regs[i], reset_word, resp_okay);
    rc(8'h50, 32'h0, resp_slverr);
    axw(8'h50, 32'h0);
    chk(34'(last_resp), 34'(resp_slverr));
    chk(34'({phy_config_pins, wide_port_a_pulldown_off}), 34'h0);
  endtask : t_reset_vals
  task automatic t_regs;
    axw(addr_endpoint_mark_mask, 32'hffffffff);
    rc(addr_endpoint_mark_mask, 32'h0000ffff, resp_okay);
    axw(addr_otg_flag_mask, 32'hffffffff);
    rc(addr_otg_flag_mask, 32'hffffffff, resp_okay);
    axw(addr_power_signalling, 32'hffffffff);
    rc(addr_power_signalling, 32'h000001ff, resp_okay);
    axw(addr_phy_control, 32'hffffffff);
    rc(addr_phy_control, 32'h00040ff0, resp_okay);
    chk(34'({phy_config_pins, wide_port_a_pulldown_off}), 34'hf);
    axw(addr_phy_control, 32'h0);
    chk(34'({phy_config_pins, wide_port_b_pulldown_off}), 34'h0);
    axw(addr_last_packet_id, 32'hffffffff);
    chk(34'(last_resp), 34'(resp_okay));
    rc(addr_last_packet_id, 32'h0, resp_okay);
  endtask : t_regs
  task automatic t_tokens;
    axw(addr_device_address, 32'h5);
    axw(addr_endpoint_mark_mask, 32'h0400);
    i_usb_phy_model.send(pid_out, 7'h05, 4'ha, 1'b0, 1'b0);
    rc(addr_last_endpoint, 32'h1a, resp_okay);
    chk(34'(port_last), 34'h1a);
    rc(addr_last_packet_id, 32'(pid_out), resp_okay);
    i_usb_phy_model.send(pid_in, 7'h05, 4'h3, 1'b0, 1'b1);
    rc(addr_last_endpoint, 32'h13, resp_okay);
    chk(34'(port_last), 34'h03);
    i_usb_phy_model.send(pid_setup, 7'h05, 4'h7, 1'b1, 1'b0);
    rc(addr_last_packet_id, 32'(pid_setup), resp_okay);
    i_usb_phy_model.send(pid_out, 7'h06, 4'h7, 1'b0, 1'b0);
    rc(addr_last_endpoint, 32'h13, resp_okay);
    // Data packet whose second byte looks like a PID
    i_usb_phy_model.send(4'h3, 7'h5a, 4'h0, 1'b0, 1'b0);
    rc(addr_last_packet_id, 32'h3, resp_okay);
    chk(34'(port_hits), 34'h2);
  endtask : t_tokens
  task automatic t_resume;
    axw(addr_phy_control, 32'h00000380);
    suspended <= 1'b1;
    i_usb_phy_model.set_line(line_k);
    repeat (3) @(posedge aclk);
    chk(34'(line_state_filtered), 34'(line_j));
    repeat (12) @(posedge aclk);
    chk(34'({line_state_filtered, resume_request}), 34'({line_k, 1'b1}));
    rc(addr_phy_control, 32'h00001380, resp_okay);
    i_usb_phy_model.set_line(line_j);
    repeat (12) @(posedge aclk);
    axw(addr_phy_control, 32'h00000380);
    rc(addr_phy_control, 32'h00000380, resp_okay);
    i_usb_phy_model.set_line(line_se0);
    repeat (12) @(posedge aclk);
    rc(addr_phy_control, 32'h00002380, resp_okay);
    // Resume still holds in the cycle the clear lands; set wins
    axw(addr_phy_control, 32'h00000300);
    rc(addr_phy_control, 32'h00002300, resp_okay);
    axw(addr_phy_control, 32'h00000300);
    rc(addr_phy_control, 32'h00000300, resp_okay);
    chk(34'(resume_request), 34'h0);
    suspended <= 1'b0;
  endtask : t_resume
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_regs();
    t_tokens();
    t_resume();
    end_of_test();
  end
endmodule : tb

// ---- usb_phy_model.sv ----
`timescale 1ns/1ps
module usb_phy_model
  import usb_tok_pkg::*;
(
  input wire logic aclk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_active,
  output logic [1:0] line_state
);
  initial begin
    rx_data = 8'h5a;
    rx_valid = 1'b0;
    rx_active = 1'b0;
    line_state = line_j;
  end
  function automatic logic [4:0] crc5(input logic [10:0] v);
    logic [4:0] c;
    c = 5'h1f;
    for (int i = 0; i < 11; i++) begin
      c = (c[4] ^ v[i]) ? ({c[3:0], 1'b0} ^ 5'h05) : {c[3:0], 1'b0};
    end
    c = ~c;
    return {c[0], c[1], c[2], c[3], c[4]};
  endfunction : crc5
  // Slow mode idles a cycle between bytes; idle data is inverted, never held
  task automatic send(input logic [3:0] pid, input logic [6:0] adr, input logic [3:0] ep,
                      input logic bad, input logic slow);
    logic [7:0] b [3];
    b[0] = {~pid, pid};
    b[1] = {ep[0], adr};
    b[2] = {crc5({ep, adr}) ^ {4'h0, bad}, ep[3:1]};
    @(posedge aclk);
    rx_active <= 1'b1;
    foreach (b[i]) begin
      rx_data <= b[i];
      rx_valid <= 1'b1;
      @(posedge aclk);
      if (slow) begin
        rx_valid <= 1'b0;
        rx_data <= ~b[i];
        @(posedge aclk);
      end
    end
    rx_valid <= 1'b0;
    rx_active <= 1'b0;
    rx_data <= ~b[2];
  endtask : send
  task automatic set_line(input logic [1:0] s);
    @(posedge aclk);
    line_state <= s;
  endtask : set_line
endmodule : usb_phy_model

// ---- usb_tok_monitor.sv ----
`timescale 1ns/1ps
module usb_tok_monitor
  import usb_tok_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic utmi_rx_valid,
  input wire logic utmi_rx_active,
  input wire logic [1:0] utmi_line_state,
  input wire logic suspended,
  input wire logic resume_request,
  input wire logic [1:0] line_state_filtered,
  input wire logic rx_port_valid,
  input wire logic [2:0] phy_config_pins,
  input wire logic wide_port_a_pulldown_off,
  input wire logic wide_port_b_pulldown_off
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  // Both halves held one cycle, then the response registers
  wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  port_pulse_a: assert property (rx_port_valid |->
    $past(utmi_rx_valid) && $past(utmi_rx_active) ##1 !rx_port_valid)
    else $error("receive port pulse without token byte");
  resume_cause_a: assert property (resume_request |-> suspended &&
    (line_state_filtered == line_se0 || line_state_filtered == line_k))
    else $error("resume request without cause");
  filt_follow_a: assert property ($changed(line_state_filtered) |->
    line_state_filtered == $past(utmi_line_state))
    else $error("filtered state differs from line");
  pulldown_pair_a: assert property (wide_port_a_pulldown_off == wide_port_b_pulldown_off)
    else $error("pulldown controls differ");
  cfg_write_a: assert property ($changed(phy_config_pins) |->
    s_axi_bvalid || $past(s_axi_bvalid))
    else $error("config pins moved without write");
endmodule : usb_tok_monitor

bind usb_token_capture_phy_ctrl usb_tok_monitor i_usb_tok_monitor (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .utmi_rx_valid, .utmi_rx_active,
  .utmi_line_state, .suspended, .resume_request, .line_state_filtered, .rx_port_valid,
  .phy_config_pins, .wide_port_a_pulldown_off, .wide_port_b_pulldown_off);

// ---- usb_tok_pkg.sv ----
package usb_tok_pkg;

  // Register byte offsets
  localparam logic [7:0] addr_device_address = 8'h08;
  localparam logic [7:0] addr_last_packet_id = 8'h2c;
  localparam logic [7:0] addr_last_endpoint = 8'h30;
  localparam logic [7:0] addr_endpoint_mark_mask = 8'h34;
  localparam logic [7:0] addr_otg_flag_mask = 8'h38;
  localparam logic [7:0] addr_power_signalling = 8'h3c;
  localparam logic [7:0] addr_phy_control = 8'h40;

  // Field positions and widths
  localparam int ep_valid_bit = 4;
  localparam int pd_disable_bit = 18;
  localparam int se0_flag_bit = 13;
  localparam int k_flag_bit = 12;
  localparam int filt_lo = 8;
  localparam int auto_resume_bit = 7;
  localparam int conf_lo = 4;
  localparam int power_width = 9;

  // Reset value and endpoint mark value
  localparam logic [31:0] reset_word = 32'h0000_0000;
  localparam logic [4:0] mark_value = 5'h10;

  // PIDs, line states
  localparam logic [3:0] pid_out = 4'h1;
  localparam logic [3:0] pid_in = 4'h9;
  localparam logic [3:0] pid_setup = 4'hd;
  localparam logic [1:0] line_se0 = 2'h0;
  localparam logic [1:0] line_j = 2'h1;
  localparam logic [1:0] line_k = 2'h2;

  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {tok_idle, tok_byte1, tok_byte2} tok_state_t;

endpackage : usb_tok_pkg

// ---- usb_token_capture_phy_ctrl.sv ----
// Behaviour
// - Latch 4-bit PID of every received packet whose check nibble is the inverse of the PID; reads back, resets zero.
// - Keep endpoint number of latest accepted token; read only, resets zero.
// - Valid bit beside endpoint set only once endpoint holds a real value.
// - 16-bit writable endpoint mark mask, one bit per endpoint, cleared at reset.
// - Marked endpoint shows on receive port ORed with 0x10.
// - Pulldown-disable bit turns off pulldowns on both wide ports.
// - Auto-resume from SE0 reset sets flag; software writes zero to clear.
// - Auto-resume from K resume sets flag; software writes zero to clear.
// - Line-state change held 2^n clocks before passing on.
// - Auto-resume enable lets suspend controller resume; else software polls filter.
// - Three PHY config pins driven straight from 3-bit control field.
// - Only tokens for programmed 7-bit device address are passed on.
`timescale 1ns/1ps
module usb_token_capture_phy_ctrl
  import usb_tok_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] utmi_rx_data,
  input wire logic utmi_rx_valid,
  input wire logic utmi_rx_active,
  input wire logic [1:0] utmi_line_state,
  input wire logic suspended,
  output logic resume_request,
  output logic [1:0] line_state_filtered,
  output logic [4:0] rx_port_data,
  output logic rx_port_valid,
  output logic [2:0] phy_config_pins,
  output logic wide_port_a_pulldown_off,
  output logic wide_port_b_pulldown_off
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [6:0] device_address;
  logic [3:0] last_packet_id;
  logic [4:0] last_endpoint;
  logic [15:0] endpoint_mark_mask;
  logic [31:0] otg_flag_mask;
  logic [8:0] power_signalling;
  logic pd_disable;
  logic se0_flag;
  logic k_flag;
  logic [3:0] filt_log2;
  logic auto_resume;
  logic [2:0] conf_field;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_value;
  logic rd_ok;
  logic wr_ok;

  axi_lite_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_value(rd_value),
    .rd_ok(rd_ok)
  );

  wire [31:0] phy_control_word = {13'h0000, pd_disable, 4'h0, se0_flag, k_flag,
                                  filt_log2, auto_resume, conf_field, 4'h0};

  wire hit_dev = (rd_addr == addr_device_address);
  wire hit_pid = (rd_addr == addr_last_packet_id);
  wire hit_ep = (rd_addr == addr_last_endpoint);
  wire hit_mask = (rd_addr == addr_endpoint_mark_mask);
  wire hit_otg = (rd_addr == addr_otg_flag_mask);
  wire hit_pwr = (rd_addr == addr_power_signalling);
  wire hit_phy = (rd_addr == addr_phy_control);

  assign rd_ok = hit_dev | hit_pid | hit_ep | hit_mask | hit_otg | hit_pwr | hit_phy;
  assign rd_value = hit_dev ? {25'h0, device_address} :
                    hit_pid ? {28'h0, last_packet_id} :
                    hit_ep ? {27'h0, last_endpoint} :
                    hit_mask ? {16'h0000, endpoint_mark_mask} :
                    hit_otg ? otg_flag_mask :
                    hit_pwr ? {23'h0, power_signalling} :
                    hit_phy ? phy_control_word : 32'h0000_0000;

  // Read-only registers accept writes silently; unmapped gets SLVERR
  assign wr_ok = (wr_addr == addr_device_address) || (wr_addr == addr_last_packet_id) ||
                 (wr_addr == addr_last_endpoint) || (wr_addr == addr_endpoint_mark_mask) ||
                 (wr_addr == addr_otg_flag_mask) || (wr_addr == addr_power_signalling) ||
                 (wr_addr == addr_phy_control);

  wire wr_dev = wr_en && (wr_addr == addr_device_address) && wr_strb[0];
  wire wr_phy = wr_en && (wr_addr == addr_phy_control);
  wire wr_mask = wr_en && (wr_addr == addr_endpoint_mark_mask);
  wire wr_otg = wr_en && (wr_addr == addr_otg_flag_mask);
  wire wr_pwr = wr_en && (wr_addr == addr_power_signalling);

  ////////////////////////////////////////////////////////////////////////////
  // Token receiver

  tok_state_t state;
  logic [7:0] tok_lo;
  logic pid_taken;
  wire [3:0] rx_pid = utmi_rx_data[3:0];
  wire pid_ok = (utmi_rx_data[7:4] == ~utmi_rx_data[3:0]);
  wire is_token = (rx_pid == pid_out) || (rx_pid == pid_in) || (rx_pid == pid_setup);
  wire [10:0] tok_field = {utmi_rx_data[2:0], tok_lo};
  wire [4:0] crc_calc = crc5(tok_field);
  // Sent CRC is inverted and goes out high bit first
  logic [4:0] crc_sent;
  for (genvar i = 0; i < 5; i++) begin : g_crc_bits
    assign crc_sent[i] = ~utmi_rx_data[7 - i];
  end
  wire crc_ok = (crc_calc == crc_sent);
  wire addr_ok = (tok_field[6:0] == device_address);
  wire [3:0] tok_ep = tok_field[10:7];
  wire tok_good = (state == tok_byte2) && utmi_rx_active && utmi_rx_valid && crc_ok && addr_ok;

  // CRC5 over the 11-bit token field, LSB first
  function automatic logic [4:0] crc5(input logic [10:0] d);
    logic [4:0] c;
    logic fb;
    c = 5'h1f;
    for (int i = 0; i < 11; i++) begin
      fb = d[i] ^ c[4];
      c = {c[3:0], 1'b0} ^ (fb ? 5'h05 : 5'h00);
    end
    return c;
  endfunction : crc5

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= tok_idle;
      tok_lo <= 8'h00;
      pid_taken <= 1'b0;
      last_packet_id <= 4'h0;
      last_endpoint <= 5'h00;
    end else if (!utmi_rx_active) begin
      state <= tok_idle;
      pid_taken <= 1'b0;
    end else if (utmi_rx_valid) begin
      unique case (state)
        tok_idle: begin
          // Only the first byte of a packet is its PID
          if (!pid_taken) begin
            pid_taken <= 1'b1;
            if (pid_ok) begin
              last_packet_id <= rx_pid;
            end
            state <= (pid_ok && is_token) ? tok_byte1 : tok_idle;
          end
        end
        tok_byte1: begin
          tok_lo <= utmi_rx_data;
          state <= tok_byte2;
        end
        tok_byte2: begin
          if (tok_good) begin
            last_endpoint <= {1'b1, tok_ep};
          end
          state <= tok_idle;
        end
      endcase
    end
  end

  // Marked endpoint carries the 0x10 marker on the receive port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_port_data <= 5'h00;
      rx_port_valid <= 1'b0;
    end else begin
      rx_port_valid <= tok_good;
      if (tok_good) begin
        rx_port_data <= endpoint_mark_mask[tok_ep] ? ({1'b0, tok_ep} | mark_value)
                                                   : {1'b0, tok_ep};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line state filter and resume

  line_state_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .log2_count(filt_log2),
    .raw_state(utmi_line_state),
    .filt_state(line_state_filtered)
  );

  // Hardware only resumes when enabled; otherwise software polls the filter
  wire resume_se0 = auto_resume && suspended && (line_state_filtered == line_se0);
  wire resume_k = auto_resume && suspended && (line_state_filtered == line_k);
  assign resume_request = resume_se0 || resume_k;

  // Set wins over a simultaneous software clear
  wire clr_se0 = wr_phy && wr_strb[1] && !wr_data[se0_flag_bit];
  wire clr_k = wr_phy && wr_strb[1] && !wr_data[k_flag_bit];
  wire next_se0 = resume_se0 || (se0_flag && !clr_se0);
  wire next_k = resume_k || (k_flag && !clr_k);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      device_address <= 7'h00;
      endpoint_mark_mask <= 16'h0000;
      otg_flag_mask <= reset_word;
      power_signalling <= 9'h000;
      pd_disable <= 1'b0;
      se0_flag <= 1'b0;
      k_flag <= 1'b0;
      filt_log2 <= 4'h0;
      auto_resume <= 1'b0;
      conf_field <= 3'h0;
    end else begin
      se0_flag <= next_se0;
      k_flag <= next_k;
      if (wr_dev) begin
        device_address <= wr_data[6:0];
      end
      for (int b = 0; b < 4; b++) begin
        if (wr_otg && wr_strb[b]) begin
          otg_flag_mask[b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
      for (int b = 0; b < 2; b++) begin
        if (wr_mask && wr_strb[b]) begin
          endpoint_mark_mask[b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
      if (wr_pwr && wr_strb[0]) begin
        power_signalling[7:0] <= wr_data[7:0];
      end
      if (wr_pwr && wr_strb[1]) begin
        power_signalling[8] <= wr_data[power_width-1];
      end
      if (wr_phy && wr_strb[0]) begin
        conf_field <= wr_data[conf_lo +: 3];
      end
      if (wr_phy && wr_strb[1]) begin
        filt_log2 <= wr_data[filt_lo +: 4];
      end
      if (wr_phy && wr_strb[0]) begin
        auto_resume <= wr_data[auto_resume_bit];
      end
      if (wr_phy && wr_strb[2]) begin
        pd_disable <= wr_data[pd_disable_bit];
      end
    end
  end

  assign phy_config_pins = conf_field;
  assign wide_port_a_pulldown_off = pd_disable;
  assign wide_port_b_pulldown_off = pd_disable;

endmodule : usb_token_capture_phy_ctrl
